// *** hdl/pbi_core.sv ***
`timescale 1ns/1ps
`default_nettype none

//
// Contract
// - ac<=x indexed call pushes pc+x+2, loads vector; 8 cycles, interrupts held.
// - ac>x indexed call loads pc+x+2, no push; 4 cycles, interrupts held.
// - x+1 vector words follow opcode; word at pc+ac+1 is destination.
// - program memory 64k x16, 32 pages of 2048, upper pc bits page.
// - the sixteenth page is reserved, never used for program storage.
// - after last address of a page, pc moves to next page start.
// - plain jump and call keep page; indexed jump/call, interrupt and return load full address.
// - interrupts held during page set and the single following instruction.
// - page zero vectors: reset 000, int0..7 at 014,018,010,01C,020,024,028,02C.
// - table data up to 60k bytes shares the program memory array.
// - table reads address only through the primary index.
// - table reads return 4, 8 or 16 bits within 4 machine cycles.
// - primary index 16 bits, four nibbles, addresses ram and table; here it addresses only the table, ram addresses come from the operand.
// - secondary index 13 bits, four nibbles, data ram only; here no ram access takes its address from it.
// - primary immediate load writes all 16 bits at once.
// - nibble moves load index nibble from ram; stores write it back as one nibble.
// - ram 0080-00BF holds 16 backup sets; restore/save in 4 cycles.
// - indexed accesses may increment primary index by 1, 2 or 4.
module pbi_core
	import pbi_pkg::*;
(
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rst_n,
	// sequencer request
	input  wire logic        req_valid,
	input  wire pbi_req_t    req,
	output logic             req_ready,
	output logic             op_done,
	output logic             int_hold,
	// program counter and stack
	output logic [15:0]      pc,
	output logic             stack_push,
	output logic [15:0]      stack_data,
	input  wire logic [15:0] stack_top,
	// program memory
	output pbi_rom_t         rom,
	input  wire logic [15:0] rom_data,
	// data ram
	output pbi_ram_t         ram,
	input  wire logic [3:0]  ram_rdata,
	// table read result and reserved page flag
	output logic [15:0]      table_data,
	output logic             table_valid,
	output logic             page_fault,
	// index registers
	output logic [15:0]      primary_index,
	output logic [12:0]      secondary_index
);

	logic [15:0] pc_q, pidx_q, ret_q, tdat_q, sdat_q;
	logic [12:0] sidx_q;
	logic [15:0] ram_addr_q;
	logic [3:0]  ram_wdata_q;
	logic        ram_rd_q, ram_wr_q, rom_rd_q, push_q;
	logic        done_q, tval_q, hold_q, page_hold_q, fault_q;
	logic        tstart;
	logic [3:0]  tlen;
	logic        tbusy, tdone;
	logic [3:0]  tstep;
	pbi_req_t    cur_q;
	logic        take;
	logic [15:0] after_q;
	logic [3:0]  work_q;
	logic        take_q;

	pbi_cycle_timer u_timer (
		.clk    (clk),
		.rst_n  (rst_n),
		.start  (tstart),
		.length (tlen),
		.busy   (tbusy),
		.done   (tdone),
		.step   (tstep)
	);

	// a new request is only taken while no multi-cycle operation runs
	assign req_ready = !tbusy && !tstart;
	assign take      = req_valid && req_ready;
	assign tstart    = take_q;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			take_q <= 1'b0;
			cur_q  <= '0;
		end else begin
			take_q <= take;
			if (take) begin
				cur_q <= req;
			end
		end
	end

	// operation length in machine cycles
	always_comb begin
		tlen = PBI_CYC_SHORT;
		unique case (cur_q.op)
			PBI_OP_INDEXED_CALL, PBI_OP_INDEXED_JUMP: begin
				tlen = (cur_q.work <= cur_q.operand[3:0]) ? PBI_CYC_LONG : PBI_CYC_SHORT;
			end
			PBI_OP_TABLE_LO, PBI_OP_TABLE_HI, PBI_OP_TABLE_BYTE, PBI_OP_TABLE_WORD: begin
				tlen = PBI_CYC_TABLE;
			end
			default: tlen = PBI_CYC_SHORT;
		endcase
	end

	assign after_q = pc_q + {12'h000, cur_q.operand[3:0]} + 16'h0002;

	// interrupt hold
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			hold_q <= 1'b0;
		end else begin
			// hold off, folded with the page-set window so the pin is one flop
			hold_q <= take || tstart || tbusy
				|| (tdone && cur_q.op == PBI_OP_SET_PAGE)
				|| (page_hold_q && !tdone);
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			page_hold_q <= 1'b0;
		end else if (tdone && cur_q.op == PBI_OP_SET_PAGE) begin
			page_hold_q <= 1'b1;
		end else if (tdone) begin
			page_hold_q <= 1'b0;
		end
	end

	// program counter
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			pc_q <= PBI_VEC_RESET;
		end else if (tdone) begin
			unique case (cur_q.op)
				PBI_OP_STEP1: pc_q <= pc_q + 16'h0001;
				PBI_OP_STEP2: pc_q <= pc_q + 16'h0002;
				PBI_OP_JUMP, PBI_OP_CALL: begin
					pc_q <= {pc_q[15:11], cur_q.operand[10:0]};
				end
				PBI_OP_SET_PAGE: pc_q <= {cur_q.operand[4:0], pc_q[10:0]} + 16'h0001;
				PBI_OP_INDEXED_JUMP, PBI_OP_INDEXED_CALL: begin
					if (cur_q.work <= cur_q.operand[3:0]) begin
						pc_q <= rom_data;
					end else begin
						pc_q <= after_q;
					end
				end
				PBI_OP_INTERRUPT: begin
					unique case (cur_q.int_no)
						3'h0: pc_q <= PBI_VEC_INT0;
						3'h1: pc_q <= PBI_VEC_INT1;
						3'h2: pc_q <= PBI_VEC_INT2;
						3'h3: pc_q <= PBI_VEC_INT3;
						3'h4: pc_q <= PBI_VEC_INT4;
						3'h5: pc_q <= PBI_VEC_INT5;
						3'h6: pc_q <= PBI_VEC_INT6;
						3'h7: pc_q <= PBI_VEC_INT7;
					endcase
				end
				PBI_OP_RETURN: pc_q <= stack_top;
				default: pc_q <= pc_q + 16'h0001;
			endcase
		end
	end

	// stack push
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			push_q <= 1'b0;
			ret_q  <= 16'h0000;
		end else begin
			push_q <= 1'b0;
			if (tstart && cur_q.op == PBI_OP_INDEXED_CALL && cur_q.work <= cur_q.operand[3:0]) begin
				push_q <= 1'b1;
				ret_q  <= after_q;
			end else if (tstart && cur_q.op == PBI_OP_CALL) begin
				push_q <= 1'b1;
				ret_q  <= pc_q + 16'h0001;
			end else if (tstart && cur_q.op == PBI_OP_INTERRUPT) begin
				push_q <= 1'b1;
				ret_q  <= pc_q;
			end
		end
	end

	// program memory fetch
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rom_rd_q <= 1'b0;
			sdat_q   <= 16'h0000;
			fault_q  <= 1'b0;
		end else begin
			rom_rd_q <= tbusy;
			unique case (cur_q.op)
				PBI_OP_INDEXED_JUMP, PBI_OP_INDEXED_CALL:
					sdat_q <= pc_q + {12'h000, cur_q.work} + 16'h0001;
				PBI_OP_TABLE_LO, PBI_OP_TABLE_HI, PBI_OP_TABLE_BYTE: sdat_q <= {1'b0, pidx_q[15:1]};
				PBI_OP_TABLE_WORD: sdat_q <= pidx_q;
				default: sdat_q <= pc_q;
			endcase
			fault_q <= (pc_q[15:11] == PBI_RESERVED_PAGE);
		end
	end

	// table read
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			tdat_q <= 16'h0000;
			tval_q <= 1'b0;
		end else begin
			tval_q <= 1'b0;
			if (tdone) begin
				unique case (cur_q.op)
					PBI_OP_TABLE_LO: begin
						tdat_q <= {12'h000, (pidx_q[0] ? rom_data[11:8] : rom_data[3:0])};
						tval_q <= 1'b1;
					end
					PBI_OP_TABLE_HI: begin
						tdat_q <= {12'h000, (pidx_q[0] ? rom_data[15:12] : rom_data[7:4])};
						tval_q <= 1'b1;
					end
					PBI_OP_TABLE_BYTE: begin
						tdat_q <= {8'h00, (pidx_q[0] ? rom_data[15:8] : rom_data[7:0])};
						tval_q <= 1'b1;
					end
					PBI_OP_TABLE_WORD: begin
						tdat_q <= rom_data;
						tval_q <= 1'b1;
					end
					default: tval_q <= 1'b0;
				endcase
			end
		end
	end

	// data ram sequencing
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ram_rd_q    <= 1'b0;
			ram_wr_q    <= 1'b0;
			ram_addr_q  <= 16'h0000;
			ram_wdata_q <= 4'h0;
		end else begin
			ram_rd_q <= 1'b0;
			ram_wr_q <= 1'b0;
			unique case (cur_q.op)
				PBI_OP_PIDX_MOVE, PBI_OP_SIDX_MOVE: begin
					ram_rd_q   <= tstart;
					ram_addr_q <= cur_q.operand;
				end
				PBI_OP_PIDX_STORE: begin
					ram_wr_q    <= tstart;
					ram_addr_q  <= cur_q.operand;
					ram_wdata_q <= pidx_q[{cur_q.sel, 2'b00} +: 4];
				end
				PBI_OP_SIDX_STORE: begin
					ram_wr_q    <= tstart;
					ram_addr_q  <= cur_q.operand;
					ram_wdata_q <= (cur_q.sel == 2'h3) ? {3'h0, sidx_q[12]}
						: sidx_q[{cur_q.sel, 2'b00} +: 4];
				end
				PBI_OP_RESTORE, PBI_OP_SAVE: begin
					// one nibble per cycle, low nibble lowest address
					ram_rd_q    <= (cur_q.op == PBI_OP_RESTORE) && (tstart || tbusy);
					ram_wr_q    <= (cur_q.op == PBI_OP_SAVE) && (tstart || tbusy);
					ram_addr_q  <= PBI_BACKUP_BASE + {10'h000, cur_q.operand[3:0], tstep[1:0]};
					ram_wdata_q <= pidx_q[{tstep[1:0], 2'b00} +: 4];
				end
				default: ram_addr_q <= ram_addr_q;
			endcase
		end
	end

	// primary index
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			pidx_q <= PBI_PIDX_RST;
		end else if (cur_q.op == PBI_OP_RESTORE && ram_rd_q) begin
			pidx_q[{ram_addr_q[1:0], 2'b00} +: 4] <= ram_rdata;
		end else if (tdone) begin
			unique case (cur_q.op)
				PBI_OP_PIDX_LOAD: pidx_q <= cur_q.operand;
				PBI_OP_PIDX_MOVE: pidx_q[{cur_q.sel, 2'b00} +: 4] <= ram_rdata;
				PBI_OP_PIDX_INC: begin
					pidx_q <= pidx_q + ((cur_q.sel == 2'h2) ? 16'h0004
						: (cur_q.sel == 2'h1) ? 16'h0002 : 16'h0001);
				end
				default: pidx_q <= pidx_q;
			endcase
		end
	end

	// secondary index
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			sidx_q <= PBI_SIDX_RST;
		end else if (tdone) begin
			unique case (cur_q.op)
				PBI_OP_SIDX_LOAD: sidx_q <= cur_q.operand[12:0];
				PBI_OP_SIDX_MOVE: begin
					if (cur_q.sel == 2'h3) begin
						sidx_q[12] <= ram_rdata[0];
					end else begin
						sidx_q[{cur_q.sel, 2'b00} +: 4] <= ram_rdata;
					end
				end
				PBI_OP_SIDX_INC: begin
					sidx_q <= sidx_q + ((cur_q.sel == 2'h2) ? 13'h0004
						: (cur_q.sel == 2'h1) ? 13'h0002 : 13'h0001);
				end
				default: sidx_q <= sidx_q;
			endcase
		end
	end

	// completion
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			done_q <= 1'b0;
		end else begin
			done_q <= tdone;
		end
	end

	assign primary_index   = pidx_q;
	assign secondary_index = sidx_q;
	assign pc              = pc_q;
	assign stack_push      = push_q;
	assign stack_data      = ret_q;
	assign rom             = '{rd: rom_rd_q, addr: sdat_q};
	assign ram             = '{rd: ram_rd_q, wr: ram_wr_q, addr: ram_addr_q, wdata: ram_wdata_q};
	assign table_data      = tdat_q;
	assign table_valid     = tval_q;
	assign page_fault      = fault_q;
	assign op_done         = done_q;
	assign int_hold        = hold_q;

endmodule : pbi_core

`default_nettype wire

// *** hdl/pbi_pkg.sv ***
package pbi_pkg;

	// program memory geometry
	localparam int PBI_PC_W        = 16;
	localparam int PBI_PAGE_W      = 5;
	localparam int PBI_INPAGE_W    = 11;
	localparam int PBI_PAGES       = 32;
	localparam int PBI_PAGE_WORDS  = 2048;
	localparam logic [4:0] PBI_RESERVED_PAGE = 5'h0F;
	localparam int PBI_TABLE_BYTES = 61440;

	// vectors in page zero
	localparam logic [15:0] PBI_VEC_RESET = 16'h0000;
	localparam logic [15:0] PBI_VEC_INT0  = 16'h0014;
	localparam logic [15:0] PBI_VEC_INT1  = 16'h0018;
	localparam logic [15:0] PBI_VEC_INT2  = 16'h0010;
	localparam logic [15:0] PBI_VEC_INT3  = 16'h001C;
	localparam logic [15:0] PBI_VEC_INT4  = 16'h0020;
	localparam logic [15:0] PBI_VEC_INT5  = 16'h0024;
	localparam logic [15:0] PBI_VEC_INT6  = 16'h0028;
	localparam logic [15:0] PBI_VEC_INT7  = 16'h002C;

	// index registers
	localparam int PBI_PIDX_W = 16;
	localparam int PBI_SIDX_W = 13;
	localparam logic [15:0] PBI_PIDX_RST = 16'h0000;
	localparam logic [12:0] PBI_SIDX_RST = 13'h0000;
	localparam logic [15:0] PBI_BACKUP_BASE = 16'h0080;

	// timing in machine cycles
	localparam logic [3:0] PBI_CYC_SHORT = 4'h4;
	localparam logic [3:0] PBI_CYC_LONG  = 4'h8;
	localparam logic [3:0] PBI_CYC_TABLE = 4'h4;

	typedef enum logic [4:0] {
		PBI_OP_NONE,
		PBI_OP_STEP1,
		PBI_OP_STEP2,
		PBI_OP_JUMP,
		PBI_OP_CALL,
		PBI_OP_INDEXED_JUMP,
		PBI_OP_INDEXED_CALL,
		PBI_OP_SET_PAGE,
		PBI_OP_INTERRUPT,
		PBI_OP_RETURN,
		PBI_OP_PIDX_LOAD,
		PBI_OP_SIDX_LOAD,
		PBI_OP_PIDX_MOVE,
		PBI_OP_PIDX_STORE,
		PBI_OP_SIDX_MOVE,
		PBI_OP_SIDX_STORE,
		PBI_OP_RESTORE,
		PBI_OP_SAVE,
		PBI_OP_TABLE_LO,
		PBI_OP_TABLE_HI,
		PBI_OP_TABLE_BYTE,
		PBI_OP_TABLE_WORD,
		PBI_OP_PIDX_INC,
		PBI_OP_SIDX_INC
	} pbi_op_t;

	// one request from the instruction sequencer
	typedef struct packed {
		pbi_op_t     op;
		logic [15:0] operand;
		logic [3:0]  work;
		logic [2:0]  int_no;
		logic [1:0]  sel;
	} pbi_req_t;

	// one data ram access
	typedef struct packed {
		logic        rd;
		logic        wr;
		logic [15:0] addr;
		logic [3:0]  wdata;
	} pbi_ram_t;

	// one program memory fetch
	typedef struct packed {
		logic        rd;
		logic [15:0] addr;
	} pbi_rom_t;

endpackage : pbi_pkg

// *** hdl/pbi_cycle_timer.sv ***
`timescale 1ns/1ps
`default_nettype none

// counts machine cycles of a multi-cycle operation; done pulses on the last one
module pbi_cycle_timer
	import pbi_pkg::*;
(
	// clock and reset
	input  wire logic       clk,
	input  wire logic       rst_n,
	// control
	input  wire logic       start,
	input  wire logic [3:0] length,
	// status
	output logic            busy,
	output logic            done,
	output logic [3:0]      step
);

	logic [3:0] left_q;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			left_q <= 4'h0;
		end else if (start) begin
			left_q <= length - 4'h1;
		end else if (left_q != 4'h0) begin
			left_q <= left_q - 4'h1;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			step <= 4'h0;
		end else if (start) begin
			step <= 4'h1;
		end else if (left_q != 4'h0) begin
			step <= step + 4'h1;
		end else begin
			step <= 4'h0;
		end
	end

	assign busy = (left_q != 4'h0);
	assign done = (left_q == 4'h1);

endmodule : pbi_cycle_timer

`default_nettype wire

// *** verif/pbi_core_properties.sv ***
`timescale 1ns/1ps
`default_nettype none
module pbi_core_checker
	import pbi_pkg::*;
(
	// clock and reset
	input wire logic        clk,
	input wire logic        rst_n,
	// sequencer side
	input wire logic        req_valid,
	input wire pbi_req_t    req,
	input wire logic        req_ready,
	input wire logic        op_done,
	input wire logic        int_hold,
	// program counter side
	input wire logic [15:0] pc,
	input wire logic        stack_push,
	input wire logic [15:0] stack_data,
	input wire logic        page_fault
);
	logic        take;
	logic        icall;
	logic        lng;
	logic        own_q;
	logic        skip_q;
	logic [15:0] ret_q;
	assign take  = req_valid && req_ready;
	assign icall = take && (req.op == PBI_OP_INDEXED_CALL);
	assign lng   = req.work <= req.operand[3:0];
	// return address of the call in flight, kept until its completion
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			own_q  <= 1'b0;
			skip_q <= 1'b0;
			ret_q  <= 16'h0000;
		end else if (icall) begin
			own_q  <= 1'b1;
			skip_q <= !lng;
			ret_q  <= pc + {12'h000, req.operand[3:0]} + 16'h0002;
		end else if (op_done) begin
			own_q  <= 1'b0;
			skip_q <= 1'b0;
		end
	end
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	a_long_call_time: assert property (icall && lng |=> (!op_done) [*7] ##[1:4] op_done)
		else $error("long indexed call done at wrong time");
	a_short_call_time: assert property (icall && !lng |=> (!op_done) [*2] ##[1:4] op_done)
		else $error("short indexed call done at wrong time");
	a_call_push: assert property (icall && lng |-> ##[1:9] stack_push)
		else $error("indexed call did not push");
	a_push_value: assert property (stack_push && own_q |-> stack_data == ret_q && !skip_q)
		else $error("bad push on indexed call");
	a_skip_target: assert property (op_done && skip_q |-> pc == ret_q)
		else $error("skipped call landed wrong");
	a_call_hold: assert property (icall |=> int_hold [*4])
		else $error("interrupts not held in call");
	a_page_hold: assert property (take && req.op == PBI_OP_SET_PAGE |=> int_hold [*4])
		else $error("interrupts not held in page set");
	a_reserved_page: assert property ($stable(pc) |-> page_fault == (pc[15:11] == PBI_RESERVED_PAGE))
		else $error("reserved page flag wrong");
	c_long_call: cover property (icall && lng);
	c_short_call: cover property (icall && !lng);
	c_reserved: cover property ($rose(page_fault));
endmodule : pbi_core_checker
bind pbi_core pbi_core_checker chk (
	.clk(clk), .rst_n(rst_n), .req_valid(req_valid), .req(req), .req_ready(req_ready),
	.op_done(op_done), .int_hold(int_hold), .pc(pc), .stack_push(stack_push),
	.stack_data(stack_data), .page_fault(page_fault)
);
`default_nettype wire

// *** verif/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) \
	begin \
		n_checks++; \
		if ((a) !== (b)) begin \
			fail_count++; \
			$display("CHECK FAILED %0t got %h want %h", $time, (a), (b)); \
		end \
	end
module tb_top
	import pbi_pkg::*;
;
	// design side
	logic        clk;
	logic        rst_n;
	logic        req_valid;
	pbi_req_t    req;
	logic        req_ready;
	logic        op_done;
	logic        int_hold;
	logic [15:0] pc;
	logic        stack_push;
	logic [15:0] stack_data;
	pbi_rom_t    rom;
	pbi_ram_t    ram;
	logic [15:0] table_data;
	logic        table_valid;
	logic        page_fault;
	logic [15:0] pidx;
	logic [12:0] sidx;
	// bench state
	logic [15:0] tgt;
	logic [15:0] got_tab;
	logic [15:0] got_stk;
	logic [15:0] v;
	logic [15:0] p0;
	logic [3:0]  x;
	logic [3:0]  w;
	logic [2:0]  ino;
	logic [3:0]  mem [0:255];
	int          seed;
	int          fail_count;
	int          n_checks;
	int          i;
	int          j;

	// program words read back as their own address plus tgt, so a wrong fetch shows
	pbi_core dut (
		.clk(clk), .rst_n(rst_n), .req_valid(req_valid), .req(req), .req_ready(req_ready),
		.op_done(op_done), .int_hold(int_hold), .pc(pc), .stack_push(stack_push),
		.stack_data(stack_data), .stack_top(got_stk), .rom(rom), .rom_data(rom.addr + tgt),
		.ram(ram), .ram_rdata(mem[ram.addr[7:0]]), .table_data(table_data),
		.table_valid(table_valid), .page_fault(page_fault), .primary_index(pidx),
		.secondary_index(sidx)
	);

	always @(posedge clk) begin
		if (ram.wr) begin
			mem[ram.addr[7:0]] <= ram.wdata;
		end
		if (table_valid) begin
			got_tab <= table_data;
		end
		if (stack_push) begin
			got_stk <= stack_data;
		end
	end

	function automatic logic [15:0] call_dest(input logic [15:0] p, input logic [3:0] ox,
			input logic [3:0] ac, input logic [15:0] t);
		if (ac <= ox) begin
			return p + {12'h000, ac} + 16'h0001 + t;
		end
		return p + {12'h000, ox} + 16'h0002;
	endfunction : call_dest

	function automatic logic [15:0] int_vec(input logic [2:0] n);
		case (n)
			3'h0: return PBI_VEC_INT0;
			3'h1: return PBI_VEC_INT1;
			3'h2: return PBI_VEC_INT2;
			3'h3: return PBI_VEC_INT3;
			3'h4: return PBI_VEC_INT4;
			3'h5: return PBI_VEC_INT5;
			3'h6: return PBI_VEC_INT6;
			default: return PBI_VEC_INT7;
		endcase
	endfunction : int_vec

	task automatic finish_test();
		if (fail_count == 0 && n_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : finish_test

	// entered and left at a falling edge
	task automatic op(input pbi_op_t o, input logic [15:0] d, input logic [3:0] ac,
			input logic [1:0] s);
		int k;
		k = 0;
		while (req_ready !== 1'b1 && k < 30) begin
			@(negedge clk);
			k++;
		end
		req       = '{o, d, ac, ino, s};
		req_valid = 1'b1;
		@(negedge clk);
		req_valid = 1'b0;
		while (op_done !== 1'b1 && k < 30) begin
			@(negedge clk);
			k++;
		end
		`CHK(k < 30, 1'b1)
		@(negedge clk);
	endtask : op

	task automatic vcall(input logic [15:0] d);
		tgt = d - pc - 16'h0001;
		op(PBI_OP_INDEXED_CALL, 16'h0000, 4'h0, 2'h0);
		`CHK(pc, d)
	endtask : vcall

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	// about 500 cycles of work expected
	initial begin
		#1000000;
		fail_count++;
		finish_test();
	end

	initial begin
		seed       = 43;
		fail_count = 0;
		n_checks   = 0;
		rst_n      = 1'b0;
		req_valid  = 1'b0;
		req        = '0;
		tgt        = 16'h0000;
		ino        = 3'h0;
		got_tab    = 16'h0000;
		got_stk    = 16'h0000;
		for (i = 0; i < 256; i++) begin
			mem[i] = 4'h0;
		end
		repeat (20) @(negedge clk);
		rst_n = 1'b1;
		@(negedge clk);
		`CHK(pc, PBI_VEC_RESET)
		`CHK(pidx, PBI_PIDX_RST)
		`CHK(sidx, PBI_SIDX_RST)
		// first two passes sit on the work <= x boundary
		for (i = 0; i < 12; i++) begin
			v = 16'($random(seed));
			x = 4'($random(seed));
			w = (i < 2) ? x + i[3:0] : v[15:12];
			op(PBI_OP_PIDX_LOAD, v, 4'h0, 2'h0);
			`CHK(pidx, v)
			op(PBI_OP_SIDX_LOAD, ~v, 4'h0, 2'h0);
			`CHK(sidx, ~v[12:0])
			tgt = 16'($random(seed));
			p0  = pc;
			op(PBI_OP_INDEXED_CALL, {12'h000, x}, w, 2'h0);
			`CHK(pc, call_dest(p0, x, w, tgt))
			if (w <= x) begin
				`CHK(got_stk, p0 + {12'h000, x} + 16'h0002)
			end
		end
		vcall(16'h0FFF);
		op(PBI_OP_STEP1, 16'h0000, 4'h0, 2'h0);
		`CHK(pc, 16'h1000)
		vcall(16'h7BFF);
		`CHK(page_fault, 1'b1)
		op(PBI_OP_SET_PAGE, 16'h0003, 4'h0, 2'h0);
		`CHK(pc, 16'h1C00)
		`CHK(int_hold, 1'b1)
		op(PBI_OP_JUMP, 16'hFABC, 4'h0, 2'h0);
		`CHK(pc, 16'h1ABC)
		`CHK(int_hold, 1'b0)
		for (i = 0; i < 3; i++) begin
			v = 16'($random(seed));
			op(PBI_OP_PIDX_LOAD, v, 4'h0, 2'h0);
			op(PBI_OP_TABLE_WORD, 16'h0000, 4'h0, 2'h0);
			`CHK(got_tab, v + tgt)
			op(PBI_OP_PIDX_LOAD, v, 4'h0, 2'h0);
			op(PBI_OP_PIDX_INC, 16'h0000, 4'h0, i[1:0]);
			p0 = v + (16'h0001 << i);
			`CHK(pidx, p0)
			x = 4'($random(seed));
			op(PBI_OP_SAVE, {12'h000, x}, 4'h0, 2'h0);
			for (j = 0; j < 4; j++) begin
				`CHK(mem[{2'b10, x, j[1:0]}], p0[4*j +: 4])
			end
			op(PBI_OP_PIDX_LOAD, ~p0, 4'h0, 2'h0);
			op(PBI_OP_RESTORE, {12'h000, x}, 4'h0, 2'h0);
			`CHK(pidx, p0)
			op(PBI_OP_PIDX_STORE, 16'h0010, 4'h0, i[1:0]);
			`CHK(mem[8'h10], p0[4*i +: 4])
			w          = 4'($random(seed));
			mem[8'h11] = w;
			op(PBI_OP_PIDX_MOVE, 16'h0011, 4'h0, i[1:0]);
			`CHK(pidx[4*i +: 4], w)
		end
		for (i = 0; i < 8; i++) begin
			ino = i[2:0];
			p0  = pc;
			op(PBI_OP_INTERRUPT, 16'h0000, 4'h0, 2'h0);
			`CHK(pc, int_vec(i[2:0]))
			`CHK(got_stk, p0)
		end
		ino = 3'h0;
		finish_test();
	end
endmodule : tb_top
`default_nettype wire
